// >>> rtl/see_cmd_logic.sv
// SPI serial EEPROM command decoder, array, status register and write timer
`timescale 1ns/1ps
`default_nettype none
module see_cmd_logic #(
  parameter int          MEM_BYTES    = see_pkg::MEM_BYTES_DEF,
  parameter int          PAGE_BYTES   = see_pkg::PAGE_BYTES_DEF,
  parameter int unsigned WRITE_CYCLES = see_pkg::WRITE_CYC_DEF
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Serial pins from the host
  input  wire see_pkg::see_pins_t pins,
  // Serial data out
  output var  logic              so,
  output var  logic              so_oe
);
  import see_pkg::*;

  localparam int AW = $clog2(MEM_BYTES);
  localparam int PW = $clog2(PAGE_BYTES);

  see_pins_t   s1_q, s2_q;
  logic        sck_prev_q;
  see_state_t  st_q;
  logic [3:0]  cnt_q;
  logic [7:0]  rx_q;
  logic [15:0] asr_q;
  logic        set_cmd_q, byte_done_q;
  logic [AW-PW-1:0] pbase_q;
  logic [PW-1:0]    poff_q;
  logic [PAGE_BYTES-1:0] pvalid_q;
  logic [7:0]  pbuf [PAGE_BYTES];
  logic [7:0]  swr_q;
  logic [7:0]  mem [MEM_BYTES];
  logic [AW-1:0] rptr_q;
  logic [7:0]  tx_q;
  logic [2:0]  txc_q;
  logic        tx_on_q, drv_q;
  see_sts_t    sts_q;
  logic [31:0] wc_q;

  logic sel, run, rise_ok, fall_ok, cs_rise;
  logic [7:0] rx_byte;
  logic [15:0] addr_in;
  logic ld_rd, ld_sts, start_arr, start_sts, latch_set, latch_clr;

  // Two-stage synchronisers for every pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q       <= '{sck: 1'b0, si: 1'b0, cs_n: 1'b1, pause_n: 1'b1, protect_n: 1'b1};
      s2_q       <= '{sck: 1'b0, si: 1'b0, cs_n: 1'b1, pause_n: 1'b1, protect_n: 1'b1};
      sck_prev_q <= 1'b0;
    end else if (ce) begin
      s1_q       <= pins;
      s2_q       <= s1_q;
      sck_prev_q <= s2_q.sck;
    end
  end

  always_comb begin
    sel     = !s2_q.cs_n;
    run     = sel && s2_q.pause_n;
    rise_ok = run && s2_q.sck && !sck_prev_q;
    fall_ok = run && !s2_q.sck && sck_prev_q;
    cs_rise = s2_q.cs_n && (st_q != ST_OPC || cnt_q != 4'h0);
    rx_byte = {rx_q[6:0], s2_q.si};
    addr_in = {asr_q[14:0], s2_q.si};
    ld_rd   = rise_ok && st_q == ST_ADDR && cnt_q == 4'(ADDR_SENT_BITS - 1) && !set_cmd_q;
    ld_sts  = rise_ok && st_q == ST_OPC && cnt_q == 4'h7 && rx_byte == OPC_STS_READ;
    start_arr = cs_rise && st_q == ST_WR && byte_done_q;
    start_sts = cs_rise && st_q == ST_SWR && byte_done_q && !(sts_q.ppe && !s2_q.protect_n);
    latch_set = cs_rise && st_q == ST_LATCH && cnt_q == 4'h0 && set_cmd_q;
    latch_clr = cs_rise && st_q == ST_LATCH && cnt_q == 4'h0 && !set_cmd_q;
  end

  // Command sequencing on sampled SCK rises
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q        <= ST_OPC;
      cnt_q       <= 4'h0;
      rx_q        <= 8'h00;
      asr_q       <= 16'h0000;
      set_cmd_q   <= 1'b0;
      byte_done_q <= 1'b0;
      pbase_q     <= '0;
      poff_q      <= '0;
      pvalid_q    <= '0;
      swr_q       <= 8'h00;
    end else if (ce) begin
      if (!sel) begin
        st_q        <= ST_OPC;
        cnt_q       <= 4'h0;
        byte_done_q <= 1'b0;
      end else if (rise_ok) begin
        cnt_q <= cnt_q + 4'h1;
        rx_q  <= rx_byte;
        unique case (st_q)
          ST_OPC: if (cnt_q == 4'h7) begin
            cnt_q <= 4'h0;
            unique case (rx_byte)
              OPC_READ:      st_q <= sts_q.write_in_progress_flag ? ST_IGN : ST_ADDR;
              OPC_WRITE:     st_q <= (sts_q.write_in_progress_flag || !sts_q.latch) ? ST_IGN : ST_ADDR;
              OPC_SET_LATCH: st_q <= sts_q.write_in_progress_flag ? ST_IGN : ST_LATCH;
              OPC_CLR_LATCH: st_q <= sts_q.write_in_progress_flag ? ST_IGN : ST_LATCH;
              OPC_STS_READ:  st_q <= ST_SRD;
              OPC_STS_WRITE: st_q <= (sts_q.write_in_progress_flag || !sts_q.latch) ? ST_IGN : ST_SWR;
              default:       st_q <= ST_IGN;
            endcase
            set_cmd_q <= (rx_byte == OPC_SET_LATCH) || (rx_byte == OPC_WRITE);
          end
          ST_ADDR: begin
            asr_q <= addr_in;
            if (cnt_q == 4'(ADDR_SENT_BITS - 1)) begin
              cnt_q <= 4'h0;
              st_q  <= set_cmd_q ? ST_WR : ST_RD;
              pbase_q  <= addr_in[AW-1:PW];
              poff_q   <= addr_in[PW-1:0];
              pvalid_q <= '0;
            end
          end
          ST_WR: begin
            byte_done_q <= (cnt_q[2:0] == 3'h7);
            cnt_q       <= {1'b0, cnt_q[2:0] + 3'h1};
            if (cnt_q[2:0] == 3'h7) begin
              pvalid_q[poff_q] <= 1'b1;
              poff_q           <= poff_q + PW'(1);
            end
          end
          ST_SWR: begin
            if (byte_done_q) begin
              st_q        <= ST_IGN;
              byte_done_q <= 1'b0;
            end else if (cnt_q == 4'h7) begin
              swr_q       <= rx_byte;
              byte_done_q <= 1'b1;
            end
          end
          ST_LATCH: st_q <= ST_IGN;
          default: ;
        endcase
      end
    end
  end

  // Page buffer holds incoming data until the write cycle starts
  always_ff @(posedge clk) begin
    if (ce && rise_ok && st_q == ST_WR && cnt_q[2:0] == 3'h7) begin
      pbuf[poff_q] <= rx_byte;
    end
  end

  // Array commit at write start; protected bytes are skipped
  always_ff @(posedge clk) begin
    if (ce && start_arr) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pvalid_q[i] && !fn_protected({pbase_q, PW'(i)}, {sts_q.bp_hi, sts_q.bp_lo})) begin
          mem[{pbase_q, PW'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // Output shifter driven on sampled SCK falls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rptr_q  <= '0;
      tx_q    <= 8'h00;
      txc_q   <= 3'h0;
      tx_on_q <= 1'b0;
      drv_q   <= 1'b0;
      so      <= 1'b0;
      so_oe   <= 1'b0;
    end else if (ce) begin
      if (!sel) begin
        tx_on_q <= 1'b0;
        drv_q   <= 1'b0;
      end else if (ld_rd) begin
        tx_q    <= mem[addr_in[AW-1:0]];
        rptr_q  <= addr_in[AW-1:0] + AW'(1);
        txc_q   <= 3'h0;
        tx_on_q <= 1'b1;
      end else if (ld_sts) begin
        tx_q    <= sts_q;
        txc_q   <= 3'h0;
        tx_on_q <= 1'b1;
      end else if (fall_ok && tx_on_q) begin
        so    <= tx_q[7];
        drv_q <= 1'b1;
        txc_q <= txc_q + 3'h1;
        if (txc_q == 3'h7) begin
          if (st_q == ST_RD) begin
            tx_q   <= mem[rptr_q];
            rptr_q <= rptr_q + AW'(1);
          end else begin
            tx_q <= sts_q;
          end
        end else begin
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
      so_oe <= drv_q && tx_on_q && run;
    end
  end

  // Status register, latch and self-timed write cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sts_q <= '{ppe: STS_PPE_RST[0], rsvd: 3'h0, bp_hi: STS_PPE_RST[1], bp_lo: STS_PPE_RST[2],
                 latch: 1'b0, write_in_progress_flag: 1'b0};
      wc_q  <= 32'h0000_0000;
    end else if (ce) begin
      if (start_arr || start_sts) begin
        sts_q.write_in_progress_flag <= 1'b1;
        wc_q      <= 32'h0000_0000;
      end else if (sts_q.write_in_progress_flag) begin
        wc_q <= wc_q + 32'h0000_0001;
        if (wc_q == WRITE_CYCLES - 1) begin
          sts_q.write_in_progress_flag   <= 1'b0;
          sts_q.latch <= 1'b0;
        end
      end
      if (start_sts) begin
        sts_q.ppe   <= swr_q[7];
        sts_q.bp_hi <= swr_q[3];
        sts_q.bp_lo <= swr_q[2];
      end
      if (latch_set) begin
        sts_q.latch <= 1'b1;
      end else if (latch_clr) begin
        sts_q.latch <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/see_pkg.sv
// Constants, types and helpers for the serial EEPROM command logic
package see_pkg;
  localparam int          MEM_BYTES_DEF  = 1024;
  localparam int          PAGE_BYTES_DEF = 16;
  localparam int          ADDR_SENT_BITS = 16;
  localparam logic [7:0]  OPC_READ       = 8'h03;
  localparam logic [7:0]  OPC_WRITE      = 8'h02;
  localparam logic [7:0]  OPC_CLR_LATCH  = 8'h04;
  localparam logic [7:0]  OPC_SET_LATCH  = 8'h06;
  localparam logic [7:0]  OPC_STS_READ   = 8'h05;
  localparam logic [7:0]  OPC_STS_WRITE  = 8'h01;
  localparam logic [1:0]  BP_NONE        = 2'h0;
  localparam logic [1:0]  BP_QTR         = 2'h1;
  localparam logic [1:0]  BP_HALF        = 2'h2;
  localparam logic [9:0]  PROT_QTR_BASE  = 10'h300;
  localparam logic [9:0]  PROT_HALF_BASE = 10'h200;
  localparam logic [2:0]  STS_PPE_RST    = 3'h0;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned T_WRITE_NS     = 5000000;
  localparam int unsigned WRITE_CYC_DEF  = T_WRITE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_RD, ST_WR, ST_SRD, ST_SWR, ST_LATCH, ST_IGN
  } see_state_t;

  typedef struct packed {
    logic       ppe;
    logic [2:0] rsvd;
    logic       bp_hi;
    logic       bp_lo;
    logic       latch;
    logic       write_in_progress_flag;
  } see_sts_t;

  typedef struct packed {
    logic sck;
    logic si;
    logic cs_n;
    logic pause_n;
    logic protect_n;
  } see_pins_t;

  function automatic logic fn_protected(input logic [9:0] a, input logic [1:0] bp);
    unique case (bp)
      BP_NONE: fn_protected = 1'b0;
      BP_QTR:  fn_protected = (a >= PROT_QTR_BASE);
      BP_HALF: fn_protected = (a >= PROT_HALF_BASE);
      default: fn_protected = 1'b1;
    endcase
  endfunction
endpackage

// >>> test/see_cmd_logic_bench.sv
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/1ps
`default_nettype none
module see_cmd_logic_bench;
  import see_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       so;
  logic       so_oe;
  logic [7:0] r;
  logic [7:0] q;
  see_pins_t  pins;
  int         oe_cnt = 0;
  int         num_errors = 0;
  int         samples_checked = 0;
  always #20 clk = ~clk;
  always @(posedge clk) if (so_oe) oe_cnt++;
  see_cmd_logic #(.WRITE_CYCLES(1200)) uut (.clk(clk), .nrst(nrst), .ce(1'b1), .pins(pins), .so(so), .so_oe(so_oe));
  see_host h (.clk(clk), .so(so), .so_oe(so_oe), .pins(pins));
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [7:0] d, input int n);
    h.sel();
    h.xfer(op, r);
    if (n > 1) h.xfer(d, r);
    h.desel();
  endtask
  task automatic sts(input logic [7:0] m, input logic [7:0] e);
    frame(OPC_STS_READ, 8'h00, 2);
    chk(r & m, e);
  endtask
  // Polls the busy bit, then checks the last status seen
  task automatic idle(input logic [7:0] m, input logic [7:0] e);
    for (int k = 0; k < 20; k++) begin
      frame(OPC_STS_READ, 8'h00, 2);
      if (r[0] === 1'b0) begin
        chk(r & m, e);
        return;
      end
    end
    num_errors++;
    end_sim();
  endtask
  task automatic wr(input logic [9:0] a, input int n, input logic [31:0] d);
    frame(OPC_SET_LATCH, 8'h00, 1);
    h.sel();
    h.xfer(OPC_WRITE, r);
    h.xfer({6'h3f, a[9:8]}, r);
    h.xfer(a[7:0], r);
    for (int i = 0; i < n; i++) h.xfer(d[31-8*i -: 8], r);
    h.desel();
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    h.sel();
    h.xfer(OPC_READ, r);
    h.xfer({6'h2a, a[9:8]}, r);
    h.xfer(a[7:0], r);
    h.xfer(8'h00, q);
    h.xfer(8'h00, r);
    h.desel();
    chk(q, e[15:8]);
    chk(r, e[7:0]);
  endtask
  initial begin
    int k;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    h.tick(4);
    sts(8'hff, 8'h00);
    frame(OPC_SET_LATCH, 8'h00, 1);
    sts(8'hff, 8'h02);
    frame(OPC_CLR_LATCH, 8'h00, 1);
    sts(8'hff, 8'h00);
    frame(OPC_SET_LATCH, OPC_WRITE, 2);
    sts(8'hff, 8'h00);
    $display("latch test done");
    wr(10'h01e, 4, 32'ha0a1a2a3);
    sts(8'hff, 8'h03);
    k = oe_cnt;
    // Refused read leaves SO released after a status bit of 0
    rd(10'h01e, 16'hffff);
    chk(8'(oe_cnt - k), 8'h00);
    idle(8'hff, 8'h00);
    rd(10'h010, 16'ha2a3);
    rd(10'h01e, 16'ha0a1);
    $display("page test done");
    wr(10'h3ff, 1, 32'h55000000);
    idle(8'hff, 8'h00);
    wr(10'h000, 1, 32'h66000000);
    idle(8'hff, 8'h00);
    rd(10'h3ff, 16'h5566);
    h.set_hold(1'b1);
    rd(10'h010, 16'ha2a3);
    h.set_hold(1'b0);
    frame(OPC_SET_LATCH, 8'h00, 1);
    frame(OPC_WRITE, 8'h01, 2);
    sts(8'h01, 8'h00);
    $display("read test done");
    frame(OPC_SET_LATCH, 8'h00, 1);
    frame(OPC_STS_WRITE, 8'hff, 2);
    idle(8'hff, 8'h8c);
    wr(10'h010, 1, 32'h11000000);
    idle(8'hff, 8'h8c);
    rd(10'h010, 16'ha2a3);
    h.set_wp(1'b0);
    frame(OPC_SET_LATCH, 8'h00, 1);
    frame(OPC_STS_WRITE, 8'h00, 2);
    idle(8'hfc, 8'h8c);
    h.set_wp(1'b1);
    frame(OPC_SET_LATCH, 8'h00, 1);
    frame(OPC_STS_WRITE, 8'h04, 2);
    idle(8'hff, 8'h04);
    wr(10'h3fe, 2, 32'h99990000);
    idle(8'hff, 8'h04);
    rd(10'h3ff, 16'h5566);
    $display("protect test done");
    end_sim();
  end
endmodule
`default_nettype wire

// >>> test/see_host.sv
// Host SPI master model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module see_host import see_pkg::*; (
  input  wire logic      clk,
  input  wire logic      so,
  input  wire logic      so_oe,
  output var  see_pins_t pins
);
  logic hold_mid = 1'b0;
  initial pins = 5'h07;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic set_wp(input logic v);
    pins.protect_n <= v;
  endtask
  task automatic set_hold(input logic v);
    hold_mid = v;
  endtask
  task automatic sel();
    pins.cs_n <= 1'b0;
    tick(6);
  endtask
  // Released SI shows the inverse of its last bit
  task automatic desel();
    tick(8);
    pins.cs_n <= 1'b1;
    pins.si   <= ~pins.si;
    tick(6);
  endtask
  // Mode 0: SI set while SCK low, SO taken just after the rise
  // Released SO reads as the inverse of its last level
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins.si <= tx[i];
      tick(5);
      pins.sck <= 1'b1;
      tick(1);
      rx[i] = so_oe ? so : ~so;
      tick(2);
      pins.sck <= 1'b0;
      if (hold_mid && i == 4) begin
        tick(2);
        pins.pause_n <= 1'b0;
        tick(16);
        pins.pause_n <= 1'b1;
        tick(2);
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> test/see_monitor.sv
// Port checks for the serial EEPROM command logic
`timescale 1ns/1ps
`default_nettype none
module see_monitor import see_pkg::*; (
  input wire logic      clk,
  input wire logic      nrst,
  input wire logic      ce,
  input wire see_pins_t pins,
  input wire logic      so,
  input wire logic      so_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  quiet_release_a: assert property ($rose(nrst) |-> !so_oe && !so) else $error("so active at release");
  desel_quiet_a: assert property (pins.cs_n [*6] |-> !so_oe) else $error("so driven unselected");
  desel_stop_a: assert property ($rose(pins.cs_n) |-> ##[1:6] !so_oe) else $error("so kept on");
  pause_stop_a: assert property ($fell(pins.pause_n) |-> ##[1:6] !so_oe) else $error("so on in pause");
  pause_quiet_a: assert property (!pins.pause_n [*6] |-> !so_oe) else $error("so driven in pause");
  oe_start_a: assert property ($rose(so_oe) |-> !pins.cs_n && pins.pause_n) else $error("bad so start");
  so_edge_a: assert property (so_oe && $changed(so) |-> !pins.sck) else $error("so moved sck high");
  oe_edge_a: assert property ($rose(so_oe) |-> !pins.sck) else $error("so on sck high");
  cover property ($rose(so_oe));
  cover property ($fell(pins.pause_n) && !pins.cs_n);
  cover property ($rose(pins.cs_n));
endmodule
bind see_cmd_logic see_monitor mon (.clk(clk), .nrst(nrst), .ce(ce), .pins(pins), .so(so), .so_oe(so_oe));
`default_nettype wire
